/* File: mamd_regs.vh */
`ifndef MAMD_REGS_VH
`define MAMD_REGS_VH
// ****************************************
// Register offsets
// ****************************************
`define MAMD_OFS_SP 8'h81
`define MAMD_OFS_DP0L 8'h82
`define MAMD_OFS_DP0H 8'h83
`define MAMD_OFS_DP1L 8'h84
`define MAMD_OFS_DP1H 8'h85
`define MAMD_OFS_P4FC 8'h92
`define MAMD_OFS_DP0X 8'h93
`define MAMD_OFS_DP1X 8'h95
`define MAMD_OFS_SPX 8'h9b
`define MAMD_OFS_PAGE 8'h9c
`define MAMD_OFS_P2 8'ha0
`define MAMD_OFS_MEMORY_CONTROL 8'hc6
`define MAMD_OFS_IAX 8'hea
`define MAMD_OFS_ADDRESS_CONTROL 8'h9d
// ****************************************
// Reset values and fields
// ****************************************
`define MAMD_RST_P4FC 8'h3f
`define MAMD_RST_ZERO 8'h00
`define MAMD_RST_P2 8'hff
`define MAMD_RST_SP 8'h07
`define MAMD_ADDRESS_CONTROL_SA 2
`define MAMD_MEMORY_CONTROL_CMA 5
`define MAMD_ADDRESS_CONTROL_AM 1:0
`define MAMD_MEMORY_CONTROL_IDM 7:6
`define MAMD_MEMORY_CONTROL_COMB 3:0
`define MAMD_AM_16 2'b00
`define MAMD_AM_PAGED 2'b01
`define MAMD_AM_CONTIG 2'b10
`define MAMD_IDM_HIGH64K 2'b00
`define MAMD_IDM_LOW 2'b01
`define MAMD_IDM_4M 2'b10
`define MAMD_IDM_SHARED 2'b11
// ****************************************
// Access kinds and map bases
// ****************************************
`define MAMD_K_FETCH 3'h0
`define MAMD_K_MOVC 3'h1
`define MAMD_K_DP0 3'h2
`define MAMD_K_DP1 3'h3
`define MAMD_K_IND 3'h4
`define MAMD_K_STACK 3'h5
`define MAMD_SRAM_HI 12'h00f
`define MAMD_SRAM_LO 12'h000
`define MAMD_SRAM_4M 12'h400
`define MAMD_CAN_LO 15'h0077
`define MAMD_CAN_4M 15'h2008
`define MAMD_EXTRA_CYC_DP 2'h1
`endif

/* File: mamd_ce_decode.v */
`timescale 1ns/100ps
// ****************************************
// Chip enable block decoder
// ****************************************
module mamd_ce_decode (
   input wire [2:0] upper_fn_i,
   input wire [21:0] addr_i,
   output reg [1:0] sel_o,
   output reg in_range_o
);
   always @* begin
      case (upper_fn_i)
         3'h4: begin
            sel_o = addr_i[18:17];
            in_range_o = ~|addr_i[21:19];
         end
         3'h5: begin
            sel_o = addr_i[19:18];
            in_range_o = ~|addr_i[21:20];
         end
         3'h6: begin
            sel_o = addr_i[20:19];
            in_range_o = ~addr_i[21];
         end
         3'h7: begin
            sel_o = addr_i[21:20];
            in_range_o = 1'b1;
         end
         default: begin
            sel_o = addr_i[16:15];
            in_range_o = ~|addr_i[21:17];
         end
      endcase
   end
endmodule // mamd_ce_decode

/* File: mamd_pin_mask.v */
`timescale 1ns/100ps
// ****************************************
// Port 4 nibble function mask
// ****************************************
module mamd_pin_mask (
   input wire [2:0] fn_i,
   output reg [3:0] mask_o
);
   always @* begin
      case (fn_i)
         3'h4: mask_o = 4'h1;
         3'h5: mask_o = 4'h3;
         3'h6: mask_o = 4'h7;
         3'h7: mask_o = 4'hf;
         default: mask_o = 4'h0;
      endcase
   end
endmodule // mamd_pin_mask

/* File: mamd_map_decoder.v */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
`include "mamd_regs.vh"
module mamd_map_decoder (
   input wire clk_sys_i,
   input wire rst_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [7:0] reg_rdata_o,
   input wire acc_req_i,
   input wire [2:0] acc_kind_i,
   input wire acc_write_i,
   input wire acc_irq_vec_i,
   input wire [21:0] pc_i,
   input wire [7:0] indirect_register_i,
   input wire [7:0] wdata_i,
   input wire demux_i,
   output reg [22:0] addr_o,
   output reg int_sram_o,
   output reg int_can_o,
   output reg ext_o,
   output reg [7:0] port0_o,
   output reg port0_oe_o,
   output reg [7:0] port1_o,
   output reg [7:0] port2_o,
   output reg [7:0] port4_o,
   output wire [7:0] port4_fn_o,
   output reg [3:0] peripheral_enables_n_o,
   output reg wr_n_o,
   output reg rd_n_o,
   output reg program_store_strobe_n_o,
   output wire [1:0] extra_cycles_o,
   output wire wide_pc_o,
   output wire [9:0] stack_sram_addr_o
);
// ****************************************
// Registers
// ****************************************
   reg [7:0] stack_pointer_low_q;
   reg [7:0] pointer0_low_byte_q;
   reg [7:0] pointer0_high_byte_q;
   reg [7:0] pointer1_low_byte_q;
   reg [7:0] pointer1_high_byte_q;
   reg [7:0] port4_function_control_q;
   reg [7:0] pointer0_extension_byte_q;
   reg [7:0] pointer1_extension_byte_q;
   reg [7:0] stack_pointer_extension_q;
   reg [7:0] program_page_register_q;
   reg [7:0] port2_latch_q;
   reg [7:0] memory_control_q;
   reg [7:0] indirect_access_extension_q;
   reg [7:0] address_control_q;
   reg [7:0] rdata_d;
   wire [1:0] address_mode;
   wire [1:0] internal_map;
   wire stack_address_mode;
   wire message_area_select;
   wire [3:0] combine_enable_bits;
   assign address_mode = address_control_q[`MAMD_ADDRESS_CONTROL_AM];
   assign stack_address_mode = address_control_q[`MAMD_ADDRESS_CONTROL_SA];
   assign internal_map = memory_control_q[`MAMD_MEMORY_CONTROL_IDM];
   assign message_area_select = memory_control_q[`MAMD_MEMORY_CONTROL_CMA];
   assign combine_enable_bits = memory_control_q[`MAMD_MEMORY_CONTROL_COMB];
   assign port4_fn_o = port4_function_control_q;

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         stack_pointer_low_q <= `MAMD_RST_SP;
         pointer0_low_byte_q <= `MAMD_RST_ZERO;
         pointer0_high_byte_q <= `MAMD_RST_ZERO;
         pointer1_low_byte_q <= `MAMD_RST_ZERO;
         pointer1_high_byte_q <= `MAMD_RST_ZERO;
         port4_function_control_q <= `MAMD_RST_P4FC;
         pointer0_extension_byte_q <= `MAMD_RST_ZERO;
         pointer1_extension_byte_q <= `MAMD_RST_ZERO;
         stack_pointer_extension_q <= `MAMD_RST_ZERO;
         program_page_register_q <= `MAMD_RST_ZERO;
         port2_latch_q <= `MAMD_RST_P2;
         memory_control_q <= `MAMD_RST_ZERO;
         address_control_q <= `MAMD_RST_ZERO;
         indirect_access_extension_q <= `MAMD_RST_ZERO;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `MAMD_OFS_SP: stack_pointer_low_q <= reg_wdata_i;
            `MAMD_OFS_DP0L: pointer0_low_byte_q <= reg_wdata_i;
            `MAMD_OFS_DP0H: pointer0_high_byte_q <= reg_wdata_i;
            `MAMD_OFS_DP1L: pointer1_low_byte_q <= reg_wdata_i;
            `MAMD_OFS_DP1H: pointer1_high_byte_q <= reg_wdata_i;
            `MAMD_OFS_P4FC: port4_function_control_q <= reg_wdata_i;
            `MAMD_OFS_DP0X: pointer0_extension_byte_q <= reg_wdata_i;
            `MAMD_OFS_DP1X: pointer1_extension_byte_q <= reg_wdata_i;
            `MAMD_OFS_SPX: stack_pointer_extension_q <= reg_wdata_i;
            `MAMD_OFS_PAGE: program_page_register_q <= reg_wdata_i;
            `MAMD_OFS_P2: port2_latch_q <= reg_wdata_i;
            `MAMD_OFS_MEMORY_CONTROL: begin
               memory_control_q <= reg_wdata_i;
               // Shared mode forbids the wide stack, so it drops here.
               if (reg_wdata_i[`MAMD_MEMORY_CONTROL_IDM] == `MAMD_IDM_SHARED) begin
                  address_control_q[`MAMD_ADDRESS_CONTROL_SA] <= 1'b0;
               end
            end
            `MAMD_OFS_ADDRESS_CONTROL: begin
               address_control_q <= {5'h00,
                  reg_wdata_i[`MAMD_ADDRESS_CONTROL_SA] &
                  (internal_map != `MAMD_IDM_SHARED),
                  reg_wdata_i[`MAMD_ADDRESS_CONTROL_AM]};
            end
            `MAMD_OFS_IAX: indirect_access_extension_q <= reg_wdata_i;
            default: begin
            end
         endcase
      end
   end

// ****************************************
// Register read port
// ****************************************
   always @* begin
      case (reg_addr_i)
         `MAMD_OFS_SP: rdata_d = stack_pointer_low_q;
         `MAMD_OFS_DP0L: rdata_d = pointer0_low_byte_q;
         `MAMD_OFS_DP0H: rdata_d = pointer0_high_byte_q;
         `MAMD_OFS_DP1L: rdata_d = pointer1_low_byte_q;
         `MAMD_OFS_DP1H: rdata_d = pointer1_high_byte_q;
         `MAMD_OFS_P4FC: rdata_d = port4_function_control_q;
         `MAMD_OFS_DP0X: rdata_d = pointer0_extension_byte_q;
         `MAMD_OFS_DP1X: rdata_d = pointer1_extension_byte_q;
         `MAMD_OFS_SPX: rdata_d = stack_pointer_extension_q;
         `MAMD_OFS_PAGE: rdata_d = program_page_register_q;
         `MAMD_OFS_P2: rdata_d = port2_latch_q;
         `MAMD_OFS_MEMORY_CONTROL: rdata_d = memory_control_q;
         `MAMD_OFS_ADDRESS_CONTROL: rdata_d = address_control_q;
         `MAMD_OFS_IAX: rdata_d = indirect_access_extension_q;
         default: rdata_d = 8'h00;
      endcase
   end

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         reg_rdata_o <= 8'h00;
      end else begin
         reg_rdata_o <= reg_rd_i ? rdata_d : 8'h00;
      end
   end

// ****************************************
// Bus mode synchroniser
// ****************************************
   // The bus mode comes from a board strap, so two flops guard against
   // metastability; a change takes effect two cycles late.
   reg demux_meta_q;
   reg demux_q;
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         demux_meta_q <= 1'b0;
         demux_q <= 1'b0;
      end else begin
         demux_meta_q <= demux_i;
         demux_q <= demux_meta_q;
      end
   end

// ****************************************
// Address generation
// ****************************************
   // The program counter is only 22 bits wide, so contiguous fetches never
   // reach the SRAM mapped above 4MB; paged fetches reach it by the page, in the shared map only.
   reg [23:0] full_addr;
   reg is_program;
   always @* begin
      is_program = 1'b0;
      full_addr = 24'h000000;
      case (acc_kind_i)
         `MAMD_K_FETCH, `MAMD_K_MOVC: begin
            is_program = 1'b1;
            if (address_mode == `MAMD_AM_PAGED) begin
               full_addr = {program_page_register_q, pc_i[15:0]};
               if (acc_irq_vec_i) begin
                  full_addr = {16'h0000, pc_i[7:0]};
               end
            end else if (address_mode == `MAMD_AM_CONTIG) begin
               full_addr = {2'b00, pc_i};
            end else begin
               full_addr = {8'h00, pc_i[15:0]};
            end
         end
         `MAMD_K_DP0: full_addr = {pointer0_extension_byte_q,
            pointer0_high_byte_q, pointer0_low_byte_q};
         `MAMD_K_DP1: full_addr = {pointer1_extension_byte_q,
            pointer1_high_byte_q, pointer1_low_byte_q};
         `MAMD_K_IND: full_addr = {indirect_access_extension_q,
            port2_latch_q, indirect_register_i};
         `MAMD_K_STACK: full_addr = {14'h0000,
            stack_pointer_extension_q[1:0], stack_pointer_low_q};
         default: full_addr = 24'h000000;
      endcase
      if (address_mode == `MAMD_AM_16) begin
         full_addr[23:16] = 8'h00;
      end
   end

// ****************************************
// Internal map decode
// ****************************************
   wire [22:0] a23;
   reg hit_sram;
   reg hit_can;
   assign a23 = full_addr[22:0];
   always @* begin
      hit_sram = 1'b0;
      // Stack traffic never leaves the chip, even with the wide stack off.
      if (acc_kind_i == `MAMD_K_STACK) begin
         hit_sram = 1'b1;
      end else if (internal_map == `MAMD_IDM_SHARED) begin
         hit_sram = ({1'b0, a23[22:12]} ==
            `MAMD_SRAM_4M);
      end else if (!is_program) begin
         case (internal_map)
            `MAMD_IDM_HIGH64K:
               hit_sram = ({1'b0, a23[22:12]} == `MAMD_SRAM_HI);
            `MAMD_IDM_LOW:
               hit_sram = ({1'b0, a23[22:12]} == `MAMD_SRAM_LO);
            default:
               hit_sram = ({1'b0, a23[22:12]} == `MAMD_SRAM_4M);
         endcase
      end
      hit_can = !is_program && (message_area_select ?
         ({1'b0, a23[22:9]} == `MAMD_CAN_4M) :
         ({1'b0, a23[22:9]} == `MAMD_CAN_LO));
   end

// ****************************************
// External enables and pins
// ****************************************
   wire [1:0] ce_sel;
   wire ce_in_range;
   wire [3:0] lo_mask;
   wire [3:0] hi_mask;
   mamd_ce_decode u_ce (
      .upper_fn_i(port4_function_control_q[5:3]),
      .addr_i(a23[21:0]),
      .sel_o(ce_sel),
      .in_range_o(ce_in_range)
   );
   mamd_pin_mask u_lo (
      .fn_i(port4_function_control_q[2:0]),
      .mask_o(lo_mask)
   );
   mamd_pin_mask u_hi (
      .fn_i(port4_function_control_q[5:3]),
      .mask_o(hi_mask)
   );

   // A combined block answers data accesses through its chip enable, reads under the program store strobe and writes under the write strobe.
   reg [3:0] ce_onehot;
   reg combined;
   reg go_ext;
   always @* begin
      ce_onehot = 4'h0;
      ce_onehot[ce_sel] = ce_in_range;
      combined = |(ce_onehot & combine_enable_bits);
      go_ext = acc_req_i & ~hit_sram & ~hit_can & ~a23[22];
   end

// ****************************************
// Output registers
// ****************************************
   // Every pin value is registered so the pads never see decode glitches.
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         addr_o <= 23'h000000;
         int_sram_o <= 1'b0;
         int_can_o <= 1'b0;
         ext_o <= 1'b0;
         port0_o <= 8'h00;
         port0_oe_o <= 1'b0;
         port1_o <= 8'h00;
         port2_o <= `MAMD_RST_P2;
         port4_o <= 8'hff;
         peripheral_enables_n_o <= 4'hf;
         wr_n_o <= 1'b1;
         rd_n_o <= 1'b1;
         program_store_strobe_n_o <= 1'b1;
      end else begin
         addr_o <= a23;
         int_sram_o <= acc_req_i & hit_sram;
         int_can_o <= acc_req_i & hit_can & ~hit_sram;
         ext_o <= go_ext;
         port2_o <= go_ext ? a23[15:8] : port2_latch_q;
         port1_o <= a23[7:0];
         port0_o <= (demux_q || (go_ext && acc_write_i)) ?
            wdata_i : a23[7:0];
         port0_oe_o <= go_ext & (~demux_q | acc_write_i);
         // Bits above 19 have no pins; the block decode still uses them.
         // Unused pin functions idle high, like a released port pin.
         port4_o[7:4] <= (go_ext ? a23[19:16] : 4'h0) | ~hi_mask;
         port4_o[3:0] <= ~(go_ext & (is_program | combined) ?
            ce_onehot & lo_mask : 4'h0);
         peripheral_enables_n_o <= ~(go_ext & ~is_program & ~combined ?
            ce_onehot : 4'h0);
         wr_n_o <= ~(go_ext & ~is_program & acc_write_i);
         rd_n_o <= ~(go_ext & ~is_program & ~acc_write_i & ~combined);
         program_store_strobe_n_o <= ~(go_ext & (is_program |
            (combined & ~acc_write_i)));
      end
   end

// ****************************************
// Timing hints for the core
// ****************************************
   // Bit 0 flags paged-mode call/return/interrupt stretch, bit 1 pointer inc.
   assign extra_cycles_o = {address_mode == `MAMD_AM_CONTIG,
      address_mode == `MAMD_AM_PAGED};
   assign wide_pc_o = (address_mode == `MAMD_AM_CONTIG);
   assign stack_sram_addr_o = {stack_pointer_extension_q[1:0],
      stack_pointer_low_q};
endmodule // mamd_map_decoder

/* File: mamd_ext_model.sv */
`timescale 1ns/100ps
// ****************************************
// External memory and peripheral model
// ****************************************
module mamd_ext_model (
   input wire clk_sys_i,
   input wire demux_i,
   input wire [7:0] port0_i,
   input wire [7:0] port1_i,
   input wire [7:0] port2_i,
   input wire [7:0] port4_i,
   input wire strobe_n_i,
   output reg [19:0] bus_addr_o
);
   // Latching only under a strobe keeps an idle bus from passing as a cycle.
   always @(posedge clk_sys_i) begin
      if (!strobe_n_i) begin
         bus_addr_o <= {port4_i[7:4], port2_i,
            demux_i ? port1_i : port0_i};
      end
   end
endmodule // mamd_ext_model

/* File: mamd_map_monitor.sv */
`timescale 1ns/100ps
`include "mamd_regs.vh"
// ****************************************
// Port checker
// ****************************************
module mamd_map_monitor (
   input wire clk_sys_i,
   input wire rst_i,
   input wire [2:0] acc_kind_i,
   input wire demux_i,
   input wire [22:0] addr_o,
   input wire int_sram_o,
   input wire int_can_o,
   input wire ext_o,
   input wire [7:0] port1_o,
   input wire [7:0] port2_o,
   input wire [7:0] port4_o,
   input wire [7:0] port4_fn_o,
   input wire [3:0] peripheral_enables_n_o,
   input wire wr_n_o,
   input wire rd_n_o,
   input wire program_store_strobe_n_o,
   input wire [1:0] extra_cycles_o,
   input wire wide_pc_o
);
   wire quiet = wr_n_o & rd_n_o & program_store_strobe_n_o;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   reset_pins_a: assert property (
      $past(rst_i) |-> quiet && port4_o == 8'hff && port4_fn_o == 8'h3f)
      else $error("pins wrong after reset");
   reset_mode_a: assert property (
      $past(rst_i) |-> extra_cycles_o == 2'b00 && !wide_pc_o)
      else $error("mode not 16-bit after reset");
   wide_pc_a: assert property (
      wide_pc_o == extra_cycles_o[1] && extra_cycles_o != 2'b11)
      else $error("wide counter flag disagrees with mode");
   int_quiet_a: assert property (
      int_sram_o || int_can_o |-> quiet && !ext_o)
      else $error("strobe on internal access");
   top_space_a: assert property (addr_o[22] |-> !ext_o)
      else $error("space above 4MB went external");
   pce_data_a: assert property (
      peripheral_enables_n_o != 4'hf |->
      $past(acc_kind_i) > `MAMD_K_MOVC && ext_o)
      else $error("peripheral enable on program access");
   prog_side_a: assert property (
      ext_o && $past(acc_kind_i) <= `MAMD_K_MOVC |->
      peripheral_enables_n_o == 4'hf && !program_store_strobe_n_o)
      else $error("program access strobes wrong");
   mid_byte_a: assert property (ext_o |-> port2_o == addr_o[15:8])
      else $error("port 2 differs from address");
   low_byte_a: assert property (
      ext_o && $past(demux_i) |-> port1_o == addr_o[7:0])
      else $error("port 1 differs from address");
   hi_nibble_a: assert property (
      ext_o && extra_cycles_o != 2'b00 && port4_fn_o[5:3] == 3'b111 |->
      port4_o[7:4] == addr_o[19:16])
      else $error("port 4 address lines wrong");
endmodule // mamd_map_monitor
bind mamd_map_decoder mamd_map_monitor mon_u (.clk_sys_i, .rst_i,
   .acc_kind_i, .demux_i, .addr_o, .int_sram_o, .int_can_o, .ext_o,
   .port1_o, .port2_o, .port4_o, .port4_fn_o, .peripheral_enables_n_o,
   .wr_n_o, .rd_n_o, .program_store_strobe_n_o, .extra_cycles_o,
   .wide_pc_o);

/* File: mamd_map_decoder_bench.sv */
`timescale 1ns/100ps
`include "mamd_regs.vh"
// ****************************************
// Bench signals and instances
// ****************************************
module mamd_map_decoder_bench;
   reg clk_sys_i = 1'b0;
   reg rst_i = 1'b1;
   reg [7:0] ra = 8'h00, rwd = 8'h00;
   reg rwr = 1'b0, rrd = 1'b0, req = 1'b0, wr = 1'b0, irq = 1'b0;
   reg demux = 1'b0;
   reg [2:0] kind = 3'h0;
   reg [21:0] pc = 22'h0;
   wire [7:0] rdata, p0, p1, p2, p4, p4fn;
   wire [22:0] addr;
   wire [3:0] pce_n;
   wire [1:0] xcyc;
   wire [9:0] stk;
   wire [19:0] bus_addr;
   wire sram, can, ext, p0oe, wr_n, rd_n, ps_n, wide;
   integer failures = 0;
   integer num_checks = 0;
   always #4 clk_sys_i = ~clk_sys_i;
   // Index and write data stay fixed; each pattern is told apart below.
   mamd_map_decoder dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .reg_addr_i(ra), .reg_wdata_i(rwd), .reg_wr_i(rwr), .reg_rd_i(rrd),
      .reg_rdata_o(rdata), .acc_req_i(req), .acc_kind_i(kind),
      .acc_write_i(wr), .acc_irq_vec_i(irq), .pc_i(pc),
      .indirect_register_i(8'h78), .wdata_i(8'ha5), .demux_i(demux),
      .addr_o(addr), .int_sram_o(sram), .int_can_o(can), .ext_o(ext),
      .port0_o(p0), .port0_oe_o(p0oe), .port1_o(p1), .port2_o(p2),
      .port4_o(p4), .port4_fn_o(p4fn), .peripheral_enables_n_o(pce_n),
      .wr_n_o(wr_n), .rd_n_o(rd_n), .program_store_strobe_n_o(ps_n),
      .extra_cycles_o(xcyc), .wide_pc_o(wide), .stack_sram_addr_o(stk));
   mamd_ext_model ext_u (.clk_sys_i(clk_sys_i), .demux_i(demux),
      .port0_i(p0), .port1_i(p1), .port2_i(p2), .port4_i(p4),
      .strobe_n_i(wr_n & rd_n & ps_n), .bus_addr_o(bus_addr));
   // ****************************************
   // Shared tasks
   // ****************************************
   task cmp(input [22:0] got, input [22:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wr_reg(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk_sys_i);
         ra <= a;
         rwd <= d;
         rwr <= 1'b1;
         @(posedge clk_sys_i);
         rwr <= 1'b0;
      end
   endtask
   task rd_chk(input [7:0] a, input [7:0] e);
      begin
         @(posedge clk_sys_i);
         ra <= a;
         rrd <= 1'b1;
         @(posedge clk_sys_i);
         rrd <= 1'b0;
         @(negedge clk_sys_i);
         cmp(rdata, e);
      end
   endtask
   task acc(input [2:0] k, input w, input v, input [21:0] a);
      begin
         @(posedge clk_sys_i);
         kind <= k;
         wr <= w;
         irq <= v;
         pc <= a;
         req <= 1'b1;
         @(posedge clk_sys_i);
         req <= 1'b0;
         @(negedge clk_sys_i);
      end
   endtask
   task bus_chk(input [19:0] e);
      begin
         @(negedge clk_sys_i);
         cmp(bus_addr, e);
      end
   endtask
   task int_chk(input [7:0] mc, input [7:0] x, input [7:0] h,
         input [3:0] e);
      begin
         wr_reg(`MAMD_OFS_MEMORY_CONTROL, mc);
         wr_reg(`MAMD_OFS_DP0X, x);
         wr_reg(`MAMD_OFS_DP0H, h);
         acc(`MAMD_K_DP0, 1'b0, 1'b0, 22'h0);
         cmp({sram, can, ext, rd_n}, e);
      end
   endtask
   task test_done;
      begin
         $display("checks %0d failures %0d", num_checks, failures);
         if (failures == 0 && num_checks > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task t_reset;
      begin
         rd_chk(`MAMD_OFS_P4FC, 8'h3f);
         cmp(p4fn, 8'h3f);
         rd_chk(`MAMD_OFS_ADDRESS_CONTROL, 8'h00);
         rd_chk(`MAMD_OFS_SP, 8'h07);
         rd_chk(`MAMD_OFS_P2, 8'hff);
         rd_chk(`MAMD_OFS_DP0X, 8'h00);
         rd_chk(8'h01, 8'h00);
         acc(`MAMD_K_FETCH, 1'b0, 1'b0, 22'h0);
         cmp({ext, ps_n, p4}, 10'h20e);
         bus_chk(20'h0);
         $display("test reset done");
      end
   endtask
   task t_modes;
      begin
         wr_reg(`MAMD_OFS_DP0X, 8'h03);
         wr_reg(`MAMD_OFS_DP0H, 8'h12);
         wr_reg(`MAMD_OFS_DP0L, 8'h34);
         acc(`MAMD_K_DP0, 1'b0, 1'b0, 22'h0);
         cmp(p4[7:4], 4'h0);
         cmp({p2, p0}, 16'h1234);
         cmp({rd_n, pce_n, xcyc}, 7'h38);
         wr_reg(`MAMD_OFS_ADDRESS_CONTROL, 8'h02);
         acc(`MAMD_K_DP0, 1'b0, 1'b0, 22'h0);
         cmp(addr, 23'h031234);
         cmp({wide, xcyc, p4[7:4]}, 7'h63);
         wr_reg(`MAMD_OFS_DP1X, 8'h25);
         wr_reg(`MAMD_OFS_DP1H, 8'h9a);
         wr_reg(`MAMD_OFS_DP1L, 8'hbc);
         demux <= 1'b1;
         repeat (2) @(posedge clk_sys_i);
         acc(`MAMD_K_DP1, 1'b0, 1'b0, 22'h0);
         cmp(addr, 23'h259abc);
         cmp({p1, pce_n}, 12'hbcb);
         bus_chk(20'h59abc);
         wr_reg(`MAMD_OFS_IAX, 8'h01);
         wr_reg(`MAMD_OFS_P2, 8'h56);
         acc(`MAMD_K_IND, 1'b1, 1'b0, 22'h0);
         cmp(addr, 23'h015678);
         cmp({wr_n, p0oe, p0}, 10'h1a5);
         wr_reg(`MAMD_OFS_ADDRESS_CONTROL, 8'h01);
         wr_reg(`MAMD_OFS_PAGE, 8'h2a);
         rd_chk(`MAMD_OFS_PAGE, 8'h2a);
         acc(`MAMD_K_FETCH, 1'b0, 1'b0, 22'h001234);
         cmp(addr, 23'h2a1234);
         cmp({xcyc, p4}, 10'h1ab);
         acc(`MAMD_K_FETCH, 1'b0, 1'b1, 22'h000013);
         cmp(addr, 23'h000013);
         $display("test modes done");
      end
   endtask
   task t_internal;
      begin
         wr_reg(`MAMD_OFS_ADDRESS_CONTROL, 8'h02);
         wr_reg(`MAMD_OFS_DP0L, 8'h10);
         int_chk(8'h00, 8'h00, 8'hf0, 4'b1001);
         int_chk(8'h00, 8'h00, 8'hee, 4'b0101);
         int_chk(8'h40, 8'h00, 8'h00, 4'b1001);
         int_chk(8'h40, 8'h00, 8'hf0, 4'b0010);
         int_chk(8'ha0, 8'h40, 8'h00, 4'b1001);
         int_chk(8'ha0, 8'h40, 8'h10, 4'b0101);
         wr_reg(`MAMD_OFS_MEMORY_CONTROL, 8'h00);
         wr_reg(`MAMD_OFS_SPX, 8'h02);
         wr_reg(`MAMD_OFS_SP, 8'h34);
         wr_reg(`MAMD_OFS_ADDRESS_CONTROL, 8'h06);
         acc(`MAMD_K_STACK, 1'b0, 1'b0, 22'h0);
         cmp(stk, 10'h234);
         cmp({sram, ext}, 2'b10);
         wr_reg(`MAMD_OFS_MEMORY_CONTROL, 8'hc0);
         rd_chk(`MAMD_OFS_ADDRESS_CONTROL, 8'h02);
         wr_reg(`MAMD_OFS_ADDRESS_CONTROL, 8'h06);
         rd_chk(`MAMD_OFS_ADDRESS_CONTROL, 8'h02);
         wr_reg(`MAMD_OFS_ADDRESS_CONTROL, 8'h01);
         wr_reg(`MAMD_OFS_PAGE, 8'h40);
         acc(`MAMD_K_FETCH, 1'b0, 1'b0, 22'h000010);
         cmp(addr, 23'h400010);
         cmp({sram, ext}, 2'b10);
         wr_reg(`MAMD_OFS_PAGE, 8'h04);
         acc(`MAMD_K_FETCH, 1'b0, 1'b0, 22'h000010);
         cmp({sram, ext}, 2'b01);
         wr_reg(`MAMD_OFS_ADDRESS_CONTROL, 8'h02);
         wr_reg(`MAMD_OFS_MEMORY_CONTROL, 8'h00);
         $display("test internal done");
      end
   endtask
   task t_enables;
      begin
         wr_reg(`MAMD_OFS_P4FC, 8'h07);
         acc(`MAMD_K_FETCH, 1'b0, 1'b0, 22'h008000);
         cmp(p4, 8'hfd);
         wr_reg(`MAMD_OFS_P4FC, 8'h27);
         acc(`MAMD_K_FETCH, 1'b0, 1'b0, 22'h020000);
         cmp(p4, 8'hed);
         wr_reg(`MAMD_OFS_P4FC, 8'h3c);
         acc(`MAMD_K_FETCH, 1'b0, 1'b0, 22'h300000);
         cmp(p4, 8'h0f);
         wr_reg(`MAMD_OFS_P4FC, 8'h3f);
         wr_reg(`MAMD_OFS_MEMORY_CONTROL, 8'h01);
         wr_reg(`MAMD_OFS_DP0X, 8'h00);
         wr_reg(`MAMD_OFS_DP0H, 8'h10);
         acc(`MAMD_K_DP0, 1'b1, 1'b0, 22'h0);
         cmp({p4[3:0], wr_n}, 5'h1c);
         acc(`MAMD_K_DP0, 1'b0, 1'b0, 22'h0);
         cmp({p4[3:0], ps_n, rd_n}, 6'h39);
         $display("test enables done");
      end
   endtask
   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_reset;
      t_modes;
      t_internal;
      t_enables;
      test_done;
   end
   initial begin
      #40000;
      failures = failures + 1;
      test_done;
   end
endmodule // mamd_map_decoder_bench
